// ==== rtl/oma_pkg.sv ====
/*
  Shared constants and types of the operating-mode and console-access
  controller. Assumes a single 200 MHz clock domain.
*/
package oma_pkg;

  // =====================================================================
  // operating modes and mode switch positions (same coding)
  typedef enum logic [1:0] {
    OMA_MD_PROGRAM = 2'h0,
    OMA_MD_MONITOR = 2'h1,
    OMA_MD_RUN     = 2'h2
  } oma_mode_t;

  // =====================================================================
  // console keys
  localparam logic [1:0] KEY_SHIFT = 2'h0;
  localparam logic [1:0] KEY_CLEAR = 2'h1;
  localparam logic [1:0] KEY_MONITOR = 2'h2;
  localparam logic [1:0] KEY_OTHER = 2'h3;

  // request kinds from the console
  localparam logic [1:0] REQ_PROG_EDIT = 2'h0;
  localparam logic [1:0] REQ_FORCE = 2'h1;
  localparam logic [1:0] REQ_VALUE = 2'h2;
  localparam logic [1:0] REQ_ONLINE = 2'h3;

  // screen contents
  localparam logic [1:0] SCR_NORMAL = 2'h0;
  localparam logic [1:0] SCR_PASSWORD = 2'h1;
  localparam logic [1:0] SCR_MODE = 2'h2;

  // =====================================================================
  // register map (word index on the plain register port)
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFS_STARTUP_CFG = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;

  // startup_mode_config fields
  localparam int CFG_SEL_LSB = 8;
  localparam int CFG_MODE_LSB = 0;
  localparam logic [7:0] CFG_SEL_SWITCH = 8'h00;
  localparam logic [7:0] CFG_SEL_RETAIN = 8'h01;
  localparam logic [7:0] CFG_SEL_WORD = 8'h02;
  localparam logic [7:0] CFG_MODE_PROGRAM = 8'h00;
  localparam logic [7:0] CFG_MODE_MONITOR = 8'h01;
  localparam logic [7:0] CFG_MODE_RUN = 8'h02;

  // status fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_PW_OK = 2;
  localparam int ST_MODE_DISP = 3;
  localparam int ST_SHIFT = 4;
  localparam int ST_CONSOLE = 5;

  // =====================================================================
  // reconnect grace time
  localparam longint CLK_HZ = 200000000;
  localparam longint RECONNECT_MS = 2000;
  localparam longint RECONNECT_CYC_DEF = RECONNECT_MS * CLK_HZ / 1000;

endpackage

// ==== rtl/oma_ctrl.sv ====
/*
  Operating-mode and console-access controller: startup mode choice,
  password gate, mode display lockout, shift state and per-mode access.
  Assumes all inputs synchronous to clk_i; reset stands for power-on;
  a non-volatile store supplies the saved config word and last mode.
*/
// Notes on behaviour
// [R1] shift key press toggles the shift state and its indicator
// [R2] console mode switch changes the mode and shows the new mode
// [R3] while the mode is shown only the clear key is taken
// [R4] shift held during a switch turn keeps the old screen
// [R5] no console at power-on starts in run mode; the code does so only for select zero and unknown selects
// [R6] program mode: no execution; editing, clearing, checking allowed
// [R7] monitor mode: executes; force, value change, online edit allowed
// [R8] run mode: executes; force and value change refused
// [R9] config select zero: switch mode with console, run without
// [R10] config select one: start in the mode held over power loss
// [R11] config select two: lower byte picks program, monitor or run
// [R12] password asked at power-on and at each fresh attach
// [R13] operator passes password with clear, monitor, then clear
// [R14] attach with power on first shows the mode already active
// [R15] password accepted switches to the mode set on the switch
// [R16] operator starts in program mode, no switch turn with key held
// [R17] reattach inside two seconds keeps screen and password
// [R18] other config select values act like select zero
`timescale 1ns/1ps
module oma_ctrl
#(
  parameter longint RECONNECT_CYC = oma_pkg::RECONNECT_CYC_DEF
) (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // non-volatile image
  input wire logic [15:0] saved_cfg_i,
  input wire oma_pkg::oma_mode_t saved_mode_i,
  // console
  input wire logic console_present_i,
  input wire oma_pkg::oma_mode_t mode_switch_i,
  input wire logic shift_held_i,
  input wire logic key_press_i,
  input wire logic [1:0] key_code_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_kind_i,
  // register port
  input wire logic [oma_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // controller state
  output oma_pkg::oma_mode_t mode_o,
  output logic exec_en_o,
  output logic pw_ok_o,
  output logic [1:0] screen_o,
  output logic shift_ind_o,
  output logic key_fwd_o,
  output logic [1:0] key_fwd_code_o,
  output logic grant_o,
  output logic refuse_o,
  output logic [15:0] cfg_o
);
  import oma_pkg::*;
  if (RECONNECT_CYC < 1 || RECONNECT_CYC > 64'hFFFFFFFF) begin
    $error("RECONNECT_CYC out of range");
  end

  typedef enum logic [5:0] {
    ST_INIT     = 6'h01,
    ST_DETACHED = 6'h02,
    ST_LOCKED   = 6'h04,
    ST_PW_CLR   = 6'h08,
    ST_PW_DONE  = 6'h10,
    ST_READY    = 6'h20
  } oma_state_t;
  // =====================================================================
  // decoding helpers
  function automatic oma_mode_t legal_mode(input oma_mode_t m);
    legal_mode = (m == OMA_MD_MONITOR || m == OMA_MD_RUN) ?
                 m : OMA_MD_PROGRAM;
  endfunction
  function automatic oma_mode_t start_mode(input logic [15:0] cfg,
      input logic console, input oma_mode_t sw, input oma_mode_t kept);
    logic [7:0] lo;
    lo = cfg[CFG_MODE_LSB +: 8];
    case (cfg[CFG_SEL_LSB +: 8])
      CFG_SEL_RETAIN: start_mode = legal_mode(kept);
      CFG_SEL_WORD: start_mode = lo == CFG_MODE_MONITOR ? OMA_MD_MONITOR :
          lo == CFG_MODE_RUN ? OMA_MD_RUN : OMA_MD_PROGRAM;
      // unknown selects fall back to the switch-or-run start
      default: start_mode = console ? legal_mode(sw) : OMA_MD_RUN;
    endcase
  endfunction
  // =====================================================================
  // state
  oma_state_t state, next_state;
  oma_mode_t mode, next_mode;
  oma_mode_t sw_q, next_sw_q;
  logic [15:0] cfg, next_cfg;
  logic [31:0] grace, next_grace;
  logic keep, next_keep;
  logic shift_st, next_shift_st;
  logic mode_disp, next_mode_disp;
  logic [1:0] screen, next_screen;
  logic key_fwd, next_key_fwd;
  logic [1:0] key_code_q, next_key_code_q;
  logic grant, next_grant;
  logic refuse, next_refuse;
  logic [15:0] rdata, next_rdata;
  logic exec_en, next_exec_en, pw_ok, next_pw_ok;
  logic key_clr, key_mon, key_shift, sw_moved, is_ready;
  always_comb begin
    key_clr = key_press_i && key_code_i == KEY_CLEAR;
    key_mon = key_press_i && key_code_i == KEY_MONITOR;
    key_shift = key_press_i && key_code_i == KEY_SHIFT;
    sw_moved = legal_mode(mode_switch_i) != sw_q;
    is_ready = state == ST_READY;
    next_state = state;
    next_mode = mode;
    next_sw_q = legal_mode(mode_switch_i);
    next_cfg = cfg;
    next_grace = grace;
    next_keep = keep;
    next_shift_st = shift_st;
    next_mode_disp = mode_disp;
    next_screen = screen;
    next_key_fwd = 1'b0;
    next_key_code_q = key_code_q;
    next_grant = 1'b0;
    next_refuse = 1'b0;
    case (state)
      ST_INIT: begin
        // [R5] [R9] [R10] [R11] [R18] startup mode select
        next_cfg = saved_cfg_i;
        next_mode = start_mode(saved_cfg_i, console_present_i,
                               mode_switch_i, saved_mode_i);
        // [R12] password at power-on
        next_state = console_present_i ? ST_LOCKED : ST_DETACHED;
        next_screen = console_present_i ? SCR_PASSWORD : SCR_NORMAL;
      end
      ST_DETACHED: begin
        if (grace != 32'h0) begin
          next_grace = grace - 32'h1;
        end else begin
          next_keep = 1'b0;
        end
        if (console_present_i) begin
          // [R17] quick reattach keeps session
          if (keep && grace != 32'h0) begin
            next_state = ST_READY;
          end else begin
            // [R12] [R14] fresh attach: prompt, current mode kept, mode display off
            next_state = ST_LOCKED;
            next_screen = SCR_PASSWORD;
            next_mode_disp = 1'b0;
            next_shift_st = 1'b0;
          end
        end
      end
      ST_LOCKED: begin
        if (key_clr) begin
          next_state = ST_PW_CLR;
        end
      end
      ST_PW_CLR: begin
        if (key_mon) begin
          // [R15] mode follows the switch at the monitor key, before the last clear
          next_state = ST_PW_DONE;
          next_mode = legal_mode(mode_switch_i);
        end else if (key_press_i && !key_clr) begin
          next_state = ST_LOCKED;
        end
      end
      ST_PW_DONE: begin
        if (key_clr) begin
          next_state = ST_READY;
          next_screen = SCR_NORMAL;
        end
      end
      ST_READY: begin
        if (sw_moved) begin
          // [R2] switch sets mode and shows it
          next_mode = legal_mode(mode_switch_i);
          // [R4] shift held keeps old screen
          if (!shift_held_i) begin
            next_mode_disp = 1'b1;
            next_screen = SCR_MODE;
          end
        end else if (mode_disp) begin
          // [R3] only clear leaves the mode display
          if (key_clr) begin
            next_mode_disp = 1'b0;
            next_screen = SCR_NORMAL;
          end
        end else if (key_shift) begin
          // [R1] shift toggle
          next_shift_st = !shift_st;
        end else if (key_press_i) begin
          next_key_fwd = 1'b1;
          next_key_code_q = key_code_i;
          next_shift_st = 1'b0;
        end
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
    // losing the console from any session state starts the grace timer
    if (state != ST_INIT && state != ST_DETACHED && !console_present_i) begin
      next_state = ST_DETACHED;
      next_keep = is_ready;
      next_grace = 32'(RECONNECT_CYC);
    end
    // [R6] program mode halts execution
    next_exec_en = next_mode != OMA_MD_PROGRAM && next_state != ST_INIT;
    next_pw_ok = next_state == ST_READY;

    // per-mode access to console requests
    if (req_valid_i) begin
      case (req_kind_i)
        // [R6] editing only in program mode
        REQ_PROG_EDIT: next_grant = is_ready && mode == OMA_MD_PROGRAM;
        // [R7] [R8] force and value change in monitor only
        REQ_FORCE, REQ_VALUE, REQ_ONLINE:
          next_grant = is_ready && mode == OMA_MD_MONITOR;
        default: next_grant = 1'b0;
      endcase
      next_refuse = !next_grant;
    end
    if (reg_wr_i && reg_addr_i == OFS_STARTUP_CFG) begin
      next_cfg = reg_wdata_i;
    end
    next_rdata = 16'h0000;
    if (reg_rd_i) begin
      if (reg_addr_i == OFS_STARTUP_CFG) begin
        next_rdata = cfg;
      end else if (reg_addr_i == OFS_STATUS) begin
        next_rdata[ST_MODE_LSB +: 2] = mode;
        next_rdata[ST_PW_OK] = is_ready;
        next_rdata[ST_MODE_DISP] = mode_disp;
        next_rdata[ST_SHIFT] = shift_st;
        next_rdata[ST_CONSOLE] = console_present_i;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_INIT;
      mode <= OMA_MD_PROGRAM;
      sw_q <= OMA_MD_PROGRAM;
      cfg <= 16'h0000;
      grace <= 32'h0;
      keep <= 1'b0;
      shift_st <= 1'b0;
      mode_disp <= 1'b0;
      screen <= SCR_NORMAL;
      key_fwd <= 1'b0;
      key_code_q <= KEY_SHIFT;
      grant <= 1'b0;
      refuse <= 1'b0;
      rdata <= 16'h0000;
      exec_en <= 1'b0;
      pw_ok <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      sw_q <= next_sw_q;
      cfg <= next_cfg;
      grace <= next_grace;
      keep <= next_keep;
      shift_st <= next_shift_st;
      mode_disp <= next_mode_disp;
      screen <= next_screen;
      key_fwd <= next_key_fwd;
      key_code_q <= next_key_code_q;
      grant <= next_grant;
      refuse <= next_refuse;
      rdata <= next_rdata;
      exec_en <= next_exec_en;
      pw_ok <= next_pw_ok;
    end
  end
  // =====================================================================
  // outputs, all straight from flip-flops
  assign mode_o = mode;
  assign exec_en_o = exec_en;
  assign pw_ok_o = pw_ok;
  assign screen_o = screen;
  assign shift_ind_o = shift_st;
  assign key_fwd_o = key_fwd;
  assign key_fwd_code_o = key_code_q;
  assign grant_o = grant;
  assign refuse_o = refuse;
  assign reg_rdata_o = rdata;
  assign cfg_o = cfg;
  // =====================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  shift_toggle_a: assert property ( // [R1]
    state == ST_READY && !mode_disp && !sw_moved && key_shift &&
    console_present_i |=> shift_st != $past(shift_st))
    else $error("shift state did not toggle");
  shift_hold_a: assert property ( // [R4]
    state == ST_READY && console_present_i && sw_moved && shift_held_i
    |=> screen == $past(screen) && !mode_disp)
    else $error("mode display shown with shift held");
  mode_lock_a: assert property ( // [R3]
    mode_disp && key_press_i |=> !key_fwd)
    else $error("key passed while mode shown");
  run_refuse_a: assert property ( // [R8]
    req_valid_i && mode == OMA_MD_RUN && req_kind_i == REQ_FORCE
    |=> refuse && !grant)
    else $error("force request accepted in run mode");
  prog_halt_a: assert property ( // [R6]
    mode == OMA_MD_PROGRAM |-> !exec_en_o)
    else $error("execution in program mode");
  // sampled reset keeps the release edge itself from starting an attempt
  no_console_run_a: assert property ( // [R5]
    rst_b_i && state == ST_INIT && !console_present_i &&
    saved_cfg_i[CFG_SEL_LSB +: 8] == CFG_SEL_SWITCH
    |=> mode == OMA_MD_RUN ##1 exec_en_o)
    else $error("no console start not in run mode");
  word_start_a: assert property ( // [R11]
    state == ST_INIT && saved_cfg_i[CFG_SEL_LSB +: 8] == CFG_SEL_WORD &&
    saved_cfg_i[CFG_MODE_LSB +: 8] == CFG_MODE_MONITOR && rst_b_i
    |=> mode == OMA_MD_MONITOR)
    else $error("config word start mode ignored");
  pw_gate_a: assert property ( // [R12]
    state == ST_INIT && console_present_i |=> !pw_ok_o [*2])
    else $error("session open without password");
  pw_mode_a: assert property ( // [R15]
    state == ST_PW_CLR && key_mon && console_present_i
    |=> mode == $past(legal_mode(mode_switch_i)))
    else $error("mode not taken from switch");
endmodule

// ==== sim/oma_console_model.sv ====
/*
  Behavioural handheld console: presence, mode switch, shift, key
  strokes and operation requests. Assumes clk_i is the controller clock.
*/
`timescale 1ns/1ps
module oma_console_model
  import oma_pkg::*;
(
  // clock
  input wire logic clk_i,
  // console lines toward the controller
  output oma_pkg::oma_mode_t mode_switch_o,
  output logic present_o,
  output logic shift_held_o,
  output logic key_press_o,
  output logic [1:0] key_code_o,
  output logic req_valid_o,
  output logic [1:0] req_kind_o
);
  // =====================================================================
  // idle levels
  initial begin
    mode_switch_o = OMA_MD_PROGRAM;
    present_o = 1'b1;
    shift_held_o = 1'b0;
    key_press_o = 1'b0;
    key_code_o = 2'h0;
    req_valid_o = 1'b0;
    req_kind_o = 2'h0;
  end

  // =====================================================================
  // strokes; code lines show the inverse once released, never a stale code
  // switch never turned inside a stroke
  task automatic press(input logic [1:0] code);
    @(posedge clk_i);
    key_press_o <= 1'b1;
    key_code_o <= code;
    @(posedge clk_i);
    key_press_o <= 1'b0;
    key_code_o <= ~code;
    #1;
  endtask

  task automatic request(input logic [1:0] kind);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_kind_o <= kind;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_kind_o <= ~kind;
    #1;
  endtask

  task automatic enter_password();
    press(KEY_CLEAR);
    press(KEY_MONITOR);
    press(KEY_CLEAR);
  endtask

  // shift is let go only after the turn has been seen
  task automatic turn(input oma_mode_t m, input logic sh);
    @(posedge clk_i);
    shift_held_o <= sh;
    mode_switch_o <= m;
    repeat (2) @(posedge clk_i);
    shift_held_o <= 1'b0;
    #1;
  endtask

  task automatic attach(input logic on);
    @(posedge clk_i);
    present_o <= on;
  endtask
endmodule

// ==== sim/tb_top.sv ====
/*
  Self-checking bench of the operating-mode controller: power-on image,
  register port and a console model. Assumes the hand-over timing.
*/
`timescale 1ns/1ps
module tb_top;
  import oma_pkg::*;
  // short grace time keeps the reattach test brief
  localparam longint GRACE = 20;
  localparam oma_mode_t PRG = OMA_MD_PROGRAM;
  localparam oma_mode_t MON = OMA_MD_MONITOR;
  localparam oma_mode_t RUN = OMA_MD_RUN;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] saved_cfg_i = 16'h0000;
  oma_mode_t saved_mode_i = OMA_MD_PROGRAM;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] reg_rdata_o;
  logic [15:0] cfg_o;
  oma_mode_t mode_sw;
  oma_mode_t mode_o;
  logic present, shift_held, key_press, req_valid;
  logic [1:0] key_code, req_kind, screen_o, key_fwd_code_o;
  logic exec_en_o, pw_ok_o, shift_ind_o, key_fwd_o, grant_o, refuse_o;
  int fail_count = 0;
  int checks = 0;

  always #2.5 clk_i = ~clk_i;

  oma_console_model con (.clk_i(clk_i), .mode_switch_o(mode_sw),
    .present_o(present), .shift_held_o(shift_held),
    .key_press_o(key_press), .key_code_o(key_code),
    .req_valid_o(req_valid), .req_kind_o(req_kind));

  oma_ctrl #(.RECONNECT_CYC(GRACE)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .saved_cfg_i(saved_cfg_i), .saved_mode_i(saved_mode_i),
    .console_present_i(present), .mode_switch_i(mode_sw),
    .shift_held_i(shift_held), .key_press_i(key_press),
    .key_code_i(key_code), .req_valid_i(req_valid), .req_kind_i(req_kind),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .mode_o(mode_o), .exec_en_o(exec_en_o), .pw_ok_o(pw_ok_o),
    .screen_o(screen_o), .shift_ind_o(shift_ind_o), .key_fwd_o(key_fwd_o),
    .key_fwd_code_o(key_fwd_code_o), .grant_o(grant_o),
    .refuse_o(refuse_o), .cfg_o(cfg_o));

  // =====================================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic power_on(input logic [15:0] cfg, input oma_mode_t kept,
      input oma_mode_t sw, input logic att);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    saved_cfg_i <= cfg;
    saved_mode_i <= kept;
    con.mode_switch_o <= sw;
    con.present_o <= att;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic startup(input logic [15:0] cfg, input oma_mode_t kept,
      input oma_mode_t sw, input logic att, input oma_mode_t exp);
    power_on(cfg, kept, sw, att);
    chk("mode", 16'(mode_o), 16'(exp));
    chk("exec", 16'(exec_en_o), 16'(exp != OMA_MD_PROGRAM));
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rdata", reg_rdata_o, exp);
  endtask

  // =====================================================================
  // tests
  initial begin
    startup(16'h0000, RUN, PRG, 1'b0, RUN);
    startup(16'h0000, RUN, MON, 1'b1, MON);
    startup(16'h0100, MON, RUN, 1'b1, MON);
    startup(16'h0200, RUN, RUN, 1'b1, PRG);
    startup(16'h0201, RUN, RUN, 1'b1, MON);
    startup(16'h0202, PRG, PRG, 1'b1, RUN);
    startup(16'h0502, RUN, MON, 1'b1, MON);
    startup(16'h0300, MON, PRG, 1'b0, RUN);
    $display("test startup done");
    power_on(16'h0000, OMA_MD_PROGRAM, OMA_MD_PROGRAM, 1'b1);
    chk("screen", 16'(screen_o), 16'(SCR_PASSWORD)); // prompt
    con.request(REQ_PROG_EDIT);
    chk("refuse", 16'(refuse_o), 16'h0001); // locked
    con.enter_password();
    chk("pw_ok", 16'(pw_ok_o), 16'h0001); // accepted
    chk("screen", 16'(screen_o), 16'(SCR_NORMAL)); // cleared
    reg_rd(OFS_STARTUP_CFG, 16'h0000); // captured word
    con.request(REQ_PROG_EDIT);
    chk("grant", 16'(grant_o), 16'h0001); // edit allowed
    con.request(REQ_FORCE);
    chk("refuse", 16'(refuse_o), 16'h0001); // force not here
    chk("exec", 16'(exec_en_o), 16'h0000); // halted
    con.press(KEY_SHIFT);
    chk("shift", 16'(shift_ind_o), 16'h0001); // set
    reg_rd(OFS_STATUS, 16'h0034); // status shows shift
    con.press(KEY_SHIFT);
    chk("shift", 16'(shift_ind_o), 16'h0000); // cleared
    $display("test password done");
    con.turn(OMA_MD_MONITOR, 1'b0);
    chk("mode", 16'(mode_o), 16'(OMA_MD_MONITOR)); // switch
    chk("screen", 16'(screen_o), 16'(SCR_MODE)); // mode shown
    con.press(KEY_OTHER);
    chk("fwd", 16'(key_fwd_o), 16'h0000); // blocked
    con.press(KEY_CLEAR);
    chk("screen", 16'(screen_o), 16'(SCR_NORMAL)); // cleared
    con.press(KEY_OTHER);
    chk("fwd", {15'h0000, key_fwd_o}, 16'h0001); // open again
    chk("fwd_code", 16'(key_fwd_code_o), 16'(KEY_OTHER)); // code
    for (int k = 1; k < 4; k++) begin
      con.request(k[1:0]);
      chk("grant", 16'(grant_o), 16'h0001); // monitor rights
    end
    chk("exec", 16'(exec_en_o), 16'h0001); // executes
    reg_rd(OFS_STATUS, 16'h0025); // status in monitor
    con.turn(OMA_MD_RUN, 1'b1);
    chk("mode", 16'(mode_o), 16'(OMA_MD_RUN)); // mode still moves
    chk("screen", 16'(screen_o), 16'(SCR_NORMAL)); // screen kept
    con.request(REQ_FORCE);
    chk("refuse", 16'(refuse_o), 16'h0001); // no forcing
    con.request(REQ_VALUE);
    chk("refuse", 16'(refuse_o), 16'h0001); // no value change
    chk("exec", 16'(exec_en_o), 16'h0001); // executes
    $display("test modes done");
    reg_wr(OFS_STARTUP_CFG, 16'h0201);
    reg_rd(OFS_STARTUP_CFG, 16'h0201); // config word kept
    chk("cfg", cfg_o, 16'h0201); // word handed to store
    reg_wr(OFS_STATUS, 16'hFFFF);
    reg_rd(OFS_STATUS, 16'h0026); // read-only status
    reg_rd(4'hF, 16'h0000); // unmapped index
    $display("test registers done");
    con.attach(1'b0);
    repeat (5) @(posedge clk_i);
    con.attach(1'b1);
    repeat (3) @(posedge clk_i);
    #1;
    chk("pw_ok", 16'(pw_ok_o), 16'h0001); // quick reattach
    chk("screen", 16'(screen_o), 16'(SCR_NORMAL)); // screen kept
    con.attach(1'b0);
    repeat (2 * GRACE) @(posedge clk_i);
    con.attach(1'b1);
    repeat (3) @(posedge clk_i);
    #1;
    chk("screen", 16'(screen_o), 16'(SCR_PASSWORD)); // fresh attach
    chk("mode", 16'(mode_o), 16'(OMA_MD_RUN)); // mode before attach
    con.turn(OMA_MD_MONITOR, 1'b0);
    chk("mode", 16'(mode_o), 16'(OMA_MD_RUN)); // locked switch
    con.enter_password();
    chk("mode", 16'(mode_o), 16'(OMA_MD_MONITOR)); // switch taken
    $display("test reattach done");
    give_verdict();
  end

  // =====================================================================
  // watchdog: tests need well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end
endmodule
